// File: mcs_pkg.sv
// Purpose: Shared constants and state types for the master clock select link
// Assumes: 125 MHz system clock, 8-bit device register space
// Notes: Both ends import this package whole
package mcs_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int SETTLE_TIME_NS = 10000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 12;
	localparam int REF_TIMEOUT_NS = 250000;
	localparam int REF_TIMEOUT_CYCLES = REF_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int REF_W = 16;

	// Device register map
	localparam logic [7:0] CLOCK_SELECT_ADDR = 8'h81;
	localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
	localparam int RESERVED_BIT = 7;
	localparam int SEL_MSB = 6;
	localparam int SEL_LSB = 4;
	localparam int RATE_BIT = 3;
	localparam int UPPER_MSB = 7;
	localparam int UPPER_LSB = 3;
	localparam int LOWER_MSB = 2;
	localparam logic [7:0] UPPER_MASK = 8'hF8;
	localparam logic [7:0] LOWER_MASK = 8'h07;
	localparam logic [7:0] RETUNE_MASK = 8'h78;

	// Phase increments, out_freq * 2^32 / 125 MHz
	localparam logic [31:0] INC_2048 = 32'h0431BDE8;
	localparam logic [31:0] INC_1544 = 32'h0329802C;

	// Host-side Wishbone register offsets (byte addresses)
	localparam logic [7:0] HOST_CMD_ADDR = 8'h00;
	localparam logic [7:0] HOST_STATUS_ADDR = 8'h04;
	localparam logic [7:0] HOST_SHADOW_ADDR = 8'h08;
	localparam int CMD_WE_BIT = 16;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_SPLIT_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;

	typedef enum logic [1:0] {
		MCS_IDLE = 2'b00,
		MCS_SPLIT = 2'b01,
		MCS_GAP = 2'b10,
		MCS_FINAL = 2'b11
	} mcs_host_state_t;

	typedef struct packed {
		logic [7:0] clk_sel;
		logic [31:0] phase;
		logic [SETTLE_W-1:0] settle;
		logic settled;
		logic ack;
		logic [7:0] rdata;
		logic [2:0] e1_sync;
		logic [2:0] t1_sync;
		logic e1_level;
		logic t1_level;
		logic ref_prev;
		logic [REF_W-1:0] ref_idle;
		logic ref_lost;
		logic clk_out;
		logic ref_clk;
	} mcs_dev_state_t;

	typedef struct packed {
		mcs_host_state_t fsm;
		logic [7:0] cmd_addr;
		logic [7:0] cmd_wdata;
		logic cmd_we;
		logic [7:0] shadow;
		logic [7:0] rdata;
		logic split;
		logic refused;
		logic req;
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wb_ack;
		logic [31:0] wb_dat;
	} mcs_host_regs_t;

endpackage

// File: mcs_bus_if.sv
// Purpose: Register port between the host controller and the clock select device
// Assumes: Both ends on one clock; req held until ack is seen
// Notes: ack is a one-cycle pulse from the device
`timescale 1ns/1ps
`default_nettype none
interface mcs_bus_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;

	modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
	modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// File: mcs_device.sv
// Purpose: Clock select register and line rate synthesizer of the line interface
// Assumes: Reference pins are asynchronous; host keeps the sub-register write split
// Notes: Register port stalls while the synthesizer settles after a retune
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - All clocks derive from one selected reference; here the line rate synthesizer runs from i_clk
// - Register port timed by synthesizer, set by register; here the port runs from i_clk and stalls until settled
// - Changing select or rate bits retunes synthesizer
// - Host keeps other bits unchanged during frequency change
// - Host treats register as upper and lower halves
// - One half changing needs one write
// - Both halves changing need two writes, any order
// - Top bit reserved, read/write, resets zero
// - Select bits choose configuration, top at six
// - Codes zero/one give 2048 or 1544 kHz
// - Other codes accept 8 to 256 kHz references
module mcs_device
	import mcs_pkg::*;
#(
	parameter logic [REF_W-1:0] REF_TIMEOUT = REF_W'(REF_TIMEOUT_CYCLES),
	parameter logic [SETTLE_W-1:0] SETTLE = SETTLE_W'(SETTLE_CYCLES)
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	mcs_bus_if.dev bus,
	input wire logic i_e1_reference_clock_in,
	input wire logic i_t1_reference_clock_in,
	output logic o_line_rate_clock_out,
	output logic o_reference_clock,
	output logic [2:0] o_synth_input_select,
	output logic o_output_line_rate_bit,
	output logic o_settled,
	output logic o_reference_lost
);

	mcs_dev_state_t state;
	mcs_dev_state_t next_state;
	logic [7:0] merged;
	logic [2:0] sel;
	logic rate;
	logic use_t1;
	logic ref_now;
	logic retune;
	logic hit;

	always_comb begin
		next_state = state;
		merged = bus.wdata;
		sel = state.clk_sel[SEL_MSB:SEL_LSB];
		rate = state.clk_sel[RATE_BIT];
		retune = 1'b0;
		// One request at a time, and none while the synthesizer is still moving
		hit = bus.req && !state.ack && state.settled;

		// Reference pins: three stages, level moves only when stages two and three agree
		next_state.e1_sync = {state.e1_sync[1:0], i_e1_reference_clock_in};
		next_state.t1_sync = {state.t1_sync[1:0], i_t1_reference_clock_in};
		if (state.e1_sync[1] == state.e1_sync[2]) begin
			next_state.e1_level = state.e1_sync[2];
		end
		if (state.t1_sync[1] == state.t1_sync[2]) begin
			next_state.t1_level = state.t1_sync[2];
		end

		// Codes zero and one pick the pin matching the rate; slow references use the E1 pin

		// Pin choice per select code; every slow reference arrives on the E1 pin
		case (sel)
			3'b000: begin
				// E1 pin for the 2048 kHz rate, T1 pin for the 1544 kHz rate
				use_t1 = rate;
			end
			3'b001: begin
				// Same pin pairing as code zero
				use_t1 = rate;
			end
			3'b010: begin
				// 8 kHz reference
				use_t1 = 1'b0;
			end
			3'b011: begin
				// 16 kHz reference
				use_t1 = 1'b0;
			end
			3'b100: begin
				// 56 kHz reference
				use_t1 = 1'b0;
			end
			3'b101: begin
				// 64 kHz reference
				use_t1 = 1'b0;
			end
			3'b110: begin
				// 128 kHz reference
				use_t1 = 1'b0;
			end
			3'b111: begin
				// 256 kHz reference
				use_t1 = 1'b0;
			end
			default: begin
				use_t1 = 1'b0;
			end
		endcase

		ref_now = use_t1 ? state.t1_level : state.e1_level;
		next_state.ref_clk = ref_now;
		next_state.ref_prev = ref_now;

		// Activity watchdog on the selected reference
		// It only flags; the synthesizer keeps running from i_clk when the reference dies
		if (ref_now != state.ref_prev) begin
			next_state.ref_idle = '0;
			next_state.ref_lost = 1'b0;
		end else if (state.ref_idle >= REF_TIMEOUT) begin
			next_state.ref_lost = 1'b1;
		end else begin
			next_state.ref_idle = state.ref_idle + REF_W'(1);
		end

		// Synthesizer: phase accumulator at the chosen line rate
		// Not a true PLL: output jitter follows i_clk, traded for a purely synchronous design
		// Rounded increments leave an error far below one ppm, fine for rate selection only
		if (rate) begin
			next_state.phase = state.phase + INC_1544;
		end else begin
			next_state.phase = state.phase + INC_2048;
		end
		next_state.clk_out = state.phase[31];

		// Settling timer after any retune
		// No retune can land mid-count, as the port stalls until settled, so hold-offs never stretch
		if (state.settle != '0) begin
			next_state.settle = state.settle - SETTLE_W'(1);
			next_state.settled = 1'b0;
		end else begin
			next_state.settled = 1'b1;
		end

		// Register port; acks are single pulses, never back to back
		next_state.ack = 1'b0;
		if (hit) begin
			next_state.ack = 1'b1;
			if (bus.addr == CLOCK_SELECT_ADDR) begin
				// Reads see the value before this edge; a write echoes what it stored
				next_state.rdata = state.clk_sel;
				if (bus.we) begin
					merged = bus.wdata;
					next_state.clk_sel = merged;
					next_state.rdata = merged;
					// Only select and rate bits retune; D7 and D2:0 are plain storage
					retune = ((merged ^ state.clk_sel) & RETUNE_MASK) != 8'h00;
					if (retune) begin
						// Retune: new increment takes effect now, port holds off meanwhile
						next_state.settle = SETTLE;
						next_state.settled = 1'b0;
					end
				end
			end else begin
				// Unmapped: reads zero, writes ignored
				next_state.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			// Field by field, so a field added later without a reset value stands out here
			state.clk_sel <= CLOCK_SELECT_RESET;
			state.phase <= '0;
			state.settle <= '0;
			state.settled <= 1'b1;
			state.ack <= 1'b0;
			state.rdata <= 8'h00;
			state.e1_sync <= 3'h0;
			state.t1_sync <= 3'h0;
			state.e1_level <= 1'b0;
			state.t1_level <= 1'b0;
			state.ref_prev <= 1'b0;
			state.ref_idle <= '0;
			state.ref_lost <= 1'b0;
			state.clk_out <= 1'b0;
			state.ref_clk <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign bus.ack = state.ack;
	assign bus.rdata = state.rdata;
	assign o_line_rate_clock_out = state.clk_out;
	assign o_reference_clock = state.ref_clk;
	assign o_synth_input_select = state.clk_sel[SEL_MSB:SEL_LSB];
	assign o_output_line_rate_bit = state.clk_sel[RATE_BIT];
	assign o_settled = state.settled;
	assign o_reference_lost = state.ref_lost;

endmodule // mcs_device
`default_nettype wire

// File: mcs_host.sv
// Purpose: Host controller writing the clock select register for software
// Assumes: Software uses classic Wishbone; device may stall while settling
// Notes: Keeps a shadow of the clock select register to split writes
`timescale 1ns/1ps
`default_nettype none
module mcs_host
	import mcs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	mcs_bus_if.host bus
);

	mcs_host_regs_t state;
	mcs_host_regs_t next_state;
	logic access;
	logic launch;
	logic [7:0] new_addr;
	logic [7:0] new_wdata;
	logic new_we;
	logic both;

	always_comb begin
		next_state = state;
		access = i_wb_cyc && i_wb_stb && !state.wb_ack;
		launch = 1'b0;
		new_addr = i_wb_sel[0] ? i_wb_dat[7:0] : state.cmd_addr;
		new_wdata = i_wb_sel[1] ? i_wb_dat[15:8] : state.cmd_wdata;
		new_we = i_wb_sel[2] ? i_wb_dat[CMD_WE_BIT] : state.cmd_we;
		both = (((new_wdata ^ state.shadow) & UPPER_MASK) != 8'h00) &&
			(((new_wdata ^ state.shadow) & LOWER_MASK) != 8'h00);
		next_state.wb_ack = access;
		if (access) begin
			next_state.wb_dat = 32'h00000000;
			case (i_wb_adr)
				HOST_CMD_ADDR: begin
					next_state.wb_dat = {15'h0000, state.cmd_we, state.cmd_wdata, state.cmd_addr};
					if (i_wb_we && i_wb_sel[0]) begin
						if (state.fsm == MCS_IDLE) begin
							launch = 1'b1;
						end else begin
							next_state.refused = 1'b1;
						end
					end
				end
				HOST_STATUS_ADDR: begin
					next_state.wb_dat = {16'h0000, state.rdata, 5'h00, state.refused, state.split,
						state.fsm != MCS_IDLE};
					if (i_wb_we && i_wb_sel[0] && i_wb_dat[ST_REFUSED_BIT]) begin
						next_state.refused = 1'b0;
					end
				end
				HOST_SHADOW_ADDR: begin
					next_state.wb_dat = {24'h000000, state.shadow};
				end
				default: begin
					next_state.wb_dat = 32'h00000000;
				end
			endcase
		end

		case (state.fsm)
			MCS_IDLE: begin
				if (launch) begin
					next_state.cmd_addr = new_addr;
					next_state.cmd_wdata = new_wdata;
					next_state.cmd_we = new_we;
					next_state.req = 1'b1;
					next_state.we = new_we;
					next_state.addr = new_addr;
					next_state.split = 1'b0;
					if (new_we && new_addr == CLOCK_SELECT_ADDR && both) begin
						// Upper half first, lower half kept, so each write changes one half
						next_state.wdata = (new_wdata & UPPER_MASK) | (state.shadow & LOWER_MASK);
						next_state.split = 1'b1;
						next_state.fsm = MCS_SPLIT;
					end else begin
						next_state.wdata = new_wdata;
						next_state.fsm = MCS_FINAL;
					end
				end
			end
			MCS_SPLIT: begin
				if (bus.ack) begin
					next_state.req = 1'b0;
					next_state.shadow = state.wdata;
					next_state.fsm = MCS_GAP;
				end
			end
			MCS_GAP: begin
				next_state.req = 1'b1;
				next_state.wdata = state.cmd_wdata;
				next_state.fsm = MCS_FINAL;
			end
			MCS_FINAL: begin
				// Waits as long as the device settles; no timeout by design
				if (bus.ack) begin
					next_state.req = 1'b0;
					next_state.rdata = bus.rdata;
					if (state.we && state.addr == CLOCK_SELECT_ADDR) begin
						next_state.shadow = state.wdata;
					end
					next_state.fsm = MCS_IDLE;
				end
			end
			default: begin
				next_state.fsm = MCS_IDLE;
				next_state.req = 1'b0;
			end
		endcase
		// A refusal in the clearing cycle still sticks
		if (access && i_wb_adr == HOST_CMD_ADDR && i_wb_we && i_wb_sel[0] && state.fsm != MCS_IDLE) begin
			next_state.refused = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= '0;
			state.shadow <= CLOCK_SELECT_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign o_wb_ack = state.wb_ack;
	assign o_wb_dat = state.wb_dat;
	assign bus.req = state.req;
	assign bus.we = state.we;
	assign bus.addr = state.addr;
	assign bus.wdata = state.wdata;

endmodule // mcs_host
`default_nettype wire

// File: mcs_chk.sv
// Purpose: Checks on the host to device clock select link
// Assumes: One clock; SETTLE equals the device instance value
// Notes: Keeps its own copy of the register
`timescale 1ns/1ps
`default_nettype none
module mcs_chk
	import mcs_pkg::*;
#(
	parameter int SETTLE = 8
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic o_settled
);
	logic [7:0] sel_q;
	logic [15:0] low_n;
	logic wr;
	assign wr = ack && we && addr == CLOCK_SELECT_ADDR;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_q <= CLOCK_SELECT_RESET;
			low_n <= 16'h0000;
		end else begin
			if (wr) begin
				sel_q <= wdata;
			end
			low_n <= o_settled ? 16'h0000 : low_n + 16'h0001;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
	ack_cause_a: assert property (ack |-> $past(req && !ack && o_settled)) else $error("ack without cause");
	req_gap_a: assert property (ack |=> !req) else $error("req kept");
	req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata})) else $error("req moved");
	write_echo_a: assert property (wr |-> rdata == wdata) else $error("bad echo");
	read_back_a: assert property (ack && !we && addr == CLOCK_SELECT_ADDR |-> rdata == sel_q) else $error("bad read");
	half_split_a: assert property (wr |-> ((wdata ^ sel_q) & UPPER_MASK) == 8'h00 ||
		((wdata ^ sel_q) & LOWER_MASK) == 8'h00) else $error("both halves");
	retune_a: assert property (wr && (wdata & RETUNE_MASK) != (sel_q & RETUNE_MASK) |=> !o_settled)
		else $error("no retune");
	no_retune_a: assert property (wr && (wdata & RETUNE_MASK) == (sel_q & RETUNE_MASK) |=> o_settled)
		else $error("stray retune");
	settle_len_a: assert property ($rose(o_settled) |-> low_n >= SETTLE && low_n <= SETTLE + 2)
		else $error("settle length");
	settle_max_a: assert property (low_n <= SETTLE + 2) else $error("settle hang");
endmodule // mcs_chk
`default_nettype wire

// File: mcs_bench.sv
// Purpose: Self-checking bench for the host and device pair
// Assumes: SETTLE 8 and REF_TIMEOUT 64 keep the run short
// Notes: Reference pins stop only when a test asks
`timescale 1ns/1ps
`default_nettype none
module mcs_bench;
	import mcs_pkg::*;
	logic i_clk, i_resetn, cyc, stb, wwe, e1, t1, run_t1, ack, lrc, rbit, settled, lost, p, refc;
	logic [7:0] adr;
	logic [31:0] dat, wdo, rd;
	logic [3:0] sel;
	logic [2:0] isel;
	logic [4:0] rc = 5'h00;
	int n_mismatch = 0;
	int checked = 0;
	int cyc_n = 0;
	mcs_bus_if mcs_bus_if_i();
	mcs_host mcs_host_i(.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(wwe),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(wdo), .o_wb_ack(ack), .bus(mcs_bus_if_i.host));
	mcs_device #(.REF_TIMEOUT(16'h0040), .SETTLE(12'h008)) mcs_device_i(.i_clk(i_clk), .i_resetn(i_resetn),
		.bus(mcs_bus_if_i.dev), .i_e1_reference_clock_in(e1), .i_t1_reference_clock_in(t1),
		.o_line_rate_clock_out(lrc), .o_reference_clock(refc), .o_synth_input_select(isel),
		.o_output_line_rate_bit(rbit), .o_settled(settled), .o_reference_lost(lost));
	mcs_chk #(.SETTLE(8)) mcs_chk_i(.i_clk(i_clk), .i_resetn(i_resetn), .req(mcs_bus_if_i.req),
		.we(mcs_bus_if_i.we), .addr(mcs_bus_if_i.addr), .wdata(mcs_bus_if_i.wdata),
		.rdata(mcs_bus_if_i.rdata), .ack(mcs_bus_if_i.ack), .o_settled(settled));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// E1 pin always runs so a lost flag proves which pin is watched
	always @(posedge i_clk) begin
		rc <= rc + 5'h01;
		e1 <= rc[4];
		t1 <= run_t1 & rc[3];
		cyc_n <= cyc_n + 1;
		if (cyc_n == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge i_clk);
		{cyc, stb, wwe, adr, dat, sel} <= {2'b11, w, a, d, s};
		do @(posedge i_clk); while (ack !== 1'b1);
		rd = wdo;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, HOST_CMD_ADDR, {15'h0000, w, d, a}, 4'h7);
		do wb(1'b0, HOST_STATUS_ADDR, 32'h0, 4'hF); while (rd[ST_BUSY_BIT] !== 1'b0);
	endtask
	task automatic rst();
		i_resetn <= 1'b0;
		repeat (10) @(posedge i_clk);
		i_resetn <= 1'b1;
	endtask
	task automatic t_reset();
		wb(1'b0, HOST_SHADOW_ADDR, 32'h0, 4'hF);
		chk(rd, 32'h0);
		dev(1'b0, CLOCK_SELECT_ADDR, 8'h00);
		chk(32'({isel, rbit, settled, rd[15:8]}), 32'({5'h01, CLOCK_SELECT_RESET}));
		wb(1'b0, 8'h0C, 32'h0, 4'hF);
		chk(rd, 32'h0);
		dev(1'b0, 8'h80, 8'h00);
		chk(32'(rd[15:8]), 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_split();
		logic [7:0] v [3] = '{8'hC8, 8'hCD, 8'h32};
		for (int i = 0; i < 3; i++) begin
			dev(1'b1, CLOCK_SELECT_ADDR, v[i]);
			chk(32'({rd[ST_SPLIT_BIT], rd[15:8]}), 32'({i == 2, v[i]}));
			dev(1'b0, CLOCK_SELECT_ADDR, 8'h00);
			chk(32'({isel, rbit, rd[15:8]}), 32'({v[i][6:3], v[i]}));
		end
		$display("t_split done");
	endtask
	task automatic t_refuse();
		wb(1'b1, HOST_CMD_ADDR, 32'h0001CD81, 4'h7);
		wb(1'b1, HOST_CMD_ADDR, 32'h00013281, 4'h7);
		do wb(1'b0, HOST_STATUS_ADDR, 32'h0, 4'hF); while (rd[ST_BUSY_BIT] !== 1'b0);
		chk(32'({rd[ST_REFUSED_BIT], rd[15:8]}), 32'h1CD);
		wb(1'b1, HOST_STATUS_ADDR, 32'h4, 4'hF);
		wb(1'b0, HOST_STATUS_ADDR, 32'h0, 4'hF);
		chk(32'(rd[ST_REFUSED_BIT]), 32'h0);
		$display("t_refuse done");
	endtask
	task automatic t_rate();
		int n;
		for (int i = 0; i < 16; i++) begin
			dev(1'b1, CLOCK_SELECT_ADDR, 8'(i * 8 + 5));
			while (settled !== 1'b1) @(negedge i_clk);
			n = 0;
			p = lrc;
			repeat (1250) begin
				@(negedge i_clk);
				n += (lrc && !p) ? 1 : 0;
				p = lrc;
			end
			// 10 us windows: 20.48 edges at 2048 kHz, 15.44 at 1544 kHz
			chk(32'(i[0] ? n inside {[15:16]} : n inside {[20:21]}), 32'h1);
			chk(32'(lost), 32'h0);
		end
		$display("t_rate done");
	endtask
	task automatic t_ref();
		dev(1'b1, CLOCK_SELECT_ADDR, 8'h0D);
		run_t1 <= 1'b0;
		repeat (200) @(negedge i_clk);
		chk(32'(lost), 32'h1);
		chk(32'(refc), 32'h0);
		run_t1 <= 1'b1;
		repeat (200) @(negedge i_clk);
		chk(32'(lost), 32'h0);
		$display("t_ref done");
	endtask
	task automatic stop_test();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		{i_resetn, cyc, stb, wwe, adr, dat, sel} = '0;
		run_t1 = 1'b1;
		rst();
		t_reset();
		t_split();
		t_refuse();
		t_rate();
		t_ref();
		rst();
		t_reset();
		stop_test();
	end
endmodule // mcs_bench
`default_nettype wire
